//--- zcd_pkg.sv
// zero-cross detector control package: register map, field positions, reset values
// assumes a 32-bit axi4-lite register bus with word-aligned registers
package zcd_pkg;
    // register byte addresses
    localparam logic [3:0] ZCD_CTRL_ADDR = 4'h0;
    localparam logic [3:0] ZCD_FLAG_ADDR = 4'h4;
    // control register field positions
    localparam int ZCD_EN_BIT = 7;
    localparam int ZCD_OUT_BIT = 5;
    localparam int ZCD_POL_BIT = 4;
    localparam int ZCD_RISE_BIT = 1;
    localparam int ZCD_FALL_BIT = 0;
    // flag register field position
    localparam int ZCD_FLAG_BIT = 0;
    // reset values of writable control and flag bits (enable comes from the fuse)
    localparam logic ZCD_POL_RST = 1'b0;
    localparam logic ZCD_RISE_RST = 1'b0;
    localparam logic ZCD_FALL_RST = 1'b0;
    localparam logic ZCD_FLAG_RST = 1'b0;
    // axi response codes
    localparam logic [1:0] ZCD_RESP_OKAY = 2'h0;
    localparam logic [1:0] ZCD_RESP_SLVERR = 2'h2;
endpackage

//--- zcd_ctrl.sv
// zero-cross detector digital control and status logic with an axi4-lite slave
// assumes the analog front end drives sink_active as an asynchronous level and the
// fuse level is stable while rst_n is low
`timescale 1ns/10ps
module zcd_ctrl
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // analog front end and configuration
    input wire logic sink_active,
    input wire logic poweron_disable_fuse,
    output logic detector_enable,
    output logic zero_cross_irq_flag,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // control and status state
    logic en_q, en_d;
    logic pol_q, pol_d;
    logic rise_q, rise_d;
    logic fall_q, fall_d;
    logic flag_q, flag_d;
    logic sync1_q, sync2_q;
    logic out_q, out_d;
    logic init_q;
    // bus state
    logic [3:0] awaddr_q, awaddr_d;
    logic aw_held_q, aw_held_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic w_held_q, w_held_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic wr_fire, rd_fire, wr_ctrl, wr_flag, rise_edge, fall_edge;
    logic [7:0] ctrl_view;

    // two-flop synchroniser; only sync2_q feeds logic
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= sink_active;
            sync2_q <= sync1_q;
        end
    end

    // polarity applied before the edge detectors so pol changes create edges
    assign out_d = sync2_q ^ pol_q;
    assign rise_edge = init_q && out_d && !out_q;
    assign fall_edge = init_q && !out_d && out_q;

    // write path: accept address and data in any order, commit when both held
    always_comb
    begin
        awaddr_d = awaddr_q;
        aw_held_d = aw_held_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        w_held_d = w_held_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            awaddr_d = s_axi_awaddr;
            aw_held_d = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
            w_held_d = 1'b1;
        end
        if (wr_fire)
        begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (awaddr_q == zcd_pkg::ZCD_CTRL_ADDR || awaddr_q == zcd_pkg::ZCD_FLAG_ADDR)
                ? zcd_pkg::ZCD_RESP_OKAY : zcd_pkg::ZCD_RESP_SLVERR;
        end
        else if (s_axi_bready && bvalid_q)
        begin
            bvalid_d = 1'b0;
        end
    end

    // holding registers are free only while no response is pending
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign wr_fire = aw_held_q && w_held_q;
    assign wr_ctrl = wr_fire && awaddr_q == zcd_pkg::ZCD_CTRL_ADDR && wstrb_q[0];
    assign wr_flag = wr_fire && awaddr_q == zcd_pkg::ZCD_FLAG_ADDR && wstrb_q[0];

    // control bits; unimplemented positions are simply not stored
    always_comb
    begin
        en_d = en_q;
        pol_d = pol_q;
        rise_d = rise_q;
        fall_d = fall_q;
        if (wr_ctrl)
        begin
            en_d = wdata_q[zcd_pkg::ZCD_EN_BIT];
            pol_d = wdata_q[zcd_pkg::ZCD_POL_BIT];
            rise_d = wdata_q[zcd_pkg::ZCD_RISE_BIT];
            fall_d = wdata_q[zcd_pkg::ZCD_FALL_BIT];
        end
    end

    // flag: write one to clear, a same-cycle edge wins over the clear
    always_comb
    begin
        flag_d = flag_q;
        if (wr_flag && wdata_q[zcd_pkg::ZCD_FLAG_BIT])
        begin
            flag_d = 1'b0;
        end
        if ((rise_edge && rise_q) || (fall_edge && fall_q))
        begin
            flag_d = 1'b1;
        end
    end

    // control view; bits 6, 3, 2 tie to zero
    always_comb
    begin
        ctrl_view = 8'h00;
        ctrl_view[zcd_pkg::ZCD_EN_BIT] = en_q;
        ctrl_view[zcd_pkg::ZCD_OUT_BIT] = out_q;
        ctrl_view[zcd_pkg::ZCD_POL_BIT] = pol_q;
        ctrl_view[zcd_pkg::ZCD_RISE_BIT] = rise_q;
        ctrl_view[zcd_pkg::ZCD_FALL_BIT] = fall_q;
    end

    // read path: one read at a time, answered the cycle after the address
    assign s_axi_arready = !rvalid_q;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rd_fire)
        begin
            rvalid_d = 1'b1;
            rresp_d = zcd_pkg::ZCD_RESP_OKAY;
            rdata_d = 32'h0000_0000;
            if (s_axi_araddr == zcd_pkg::ZCD_CTRL_ADDR)
            begin
                rdata_d = {24'h00_0000, ctrl_view};
            end
            else if (s_axi_araddr == zcd_pkg::ZCD_FLAG_ADDR)
            begin
                rdata_d = {31'h0000_0000, flag_q};
            end
            else
            begin
                rresp_d = zcd_pkg::ZCD_RESP_SLVERR;
            end
        end
        else if (s_axi_rready && rvalid_q)
        begin
            rvalid_d = 1'b0;
        end
    end

    // registers; enable reset value comes from the fuse after release
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            en_q <= 1'b0;
            init_q <= 1'b0;
            pol_q <= zcd_pkg::ZCD_POL_RST;
            rise_q <= zcd_pkg::ZCD_RISE_RST;
            fall_q <= zcd_pkg::ZCD_FALL_RST;
            flag_q <= zcd_pkg::ZCD_FLAG_RST;
            out_q <= 1'b0;
            awaddr_q <= 4'h0;
            aw_held_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end
        else
        begin
            // first cycle out of reset captures the fuse and primes edge history
            en_q <= init_q ? en_d : !poweron_disable_fuse;
            init_q <= 1'b1;
            pol_q <= pol_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
            flag_q <= flag_d;
            out_q <= out_d;
            awaddr_q <= awaddr_d;
            aw_held_q <= aw_held_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            w_held_q <= w_held_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // outputs
    assign detector_enable = en_q;
    assign zero_cross_irq_flag = flag_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // status follows the synchronised front end through the polarity
    a_status_follow: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> out_q == ($past(sync2_q) ^ $past(pol_q)))
        else $error("status bit does not follow front end");
    // each enabled edge must leave the flag set one cycle later
    a_rise_sets: assert property (@(posedge clk) disable iff (!rst_n)
        (init_q && rise_q && out_d && !out_q) |=> flag_q)
        else $error("rising edge did not set flag");
    a_fall_sets: assert property (@(posedge clk) disable iff (!rst_n)
        (init_q && fall_q && !out_d && out_q) |=> flag_q)
        else $error("falling edge did not set flag");
    a_no_spurious: assert property (@(posedge clk) disable iff (!rst_n)
        (!flag_q && !(rise_q && rise_edge) && !(fall_q && fall_edge)) |=> !flag_q)
        else $error("flag set without enabled edge");
    // the inverted view must reach the edge detectors, not only the status bit
    a_pol_detect: assert property (@(posedge clk) disable iff (!rst_n)
        (init_q && pol_q && $stable(pol_q) && $fell(sync2_q) && rise_q) |=> flag_q)
        else $error("inverted output edge did not set flag");
    // the flag is sticky: only a write of one to its register may drop it
    a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        (flag_q && !(wr_flag && wdata_q[zcd_pkg::ZCD_FLAG_BIT])) |=> flag_q)
        else $error("flag dropped without a clear");
    a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_flag && wdata_q[zcd_pkg::ZCD_FLAG_BIT] && !(rise_q && rise_edge)
        && !(fall_q && fall_edge)) |=> !flag_q)
        else $error("flag clear was not honoured");
    a_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (rvalid_q && rresp_q == zcd_pkg::ZCD_RESP_OKAY) |-> rdata_q[6] == 1'b0 && rdata_q[3:2] == 2'b00)
        else $error("unimplemented bits read nonzero");
    a_pol_edge: assert property (@(posedge clk) disable iff (!rst_n)
        (init_q && $changed(pol_q) && $stable(sync2_q) && rise_q && fall_q) |=> flag_q)
        else $error("polarity change did not set flag");
    // no disable here: the check spans the first edge out of reset
    a_fuse_reset: assert property (@(posedge clk)
        (rst_n && !init_q) |=> en_q == !$past(poweron_disable_fuse))
        else $error("enable reset value does not follow fuse");
    a_status_ro: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ctrl |=> out_q == ($past(sync2_q) ^ $past(pol_q)))
        else $error("status bit affected by write");
    // bus handshake hold, guards the response a slow master has not yet taken
    a_bresp_wait: assert property (@(posedge clk) disable iff (!rst_n)
        (bvalid_q && !s_axi_bready) |=> bvalid_q && $stable(bresp_q))
        else $error("write response dropped early");
endmodule

//--- zcd_front_model.sv
// behavioural model of the analog front end that sources or sinks current
// assumes the bench commands the state; the comparator settles a few ns after the command
`timescale 1ns/10ps
module zcd_front_model
(
    // commanded state from the bench, 1 = sinking
    input wire logic sink_cmd,
    // level seen by the detector logic
    output wire logic sink_active
);
    // the delay keeps switching off the clock edge, as a real comparator would be
    assign #3 sink_active = sink_cmd;
endmodule

//--- testbench.sv
// self-checking bench for the zero-cross control block, driven over axi4-lite
// assumes the front end model beside it and the block's bus answering within 40 cycles
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic clk, rst_n, sink_cmd, sink_active, fuse, det_en, flag;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int n_errors, checks;
    // per step: control value, new sink state, expected flag
    logic [7:0] c_tab [7] = '{8'h02, 8'h02, 8'h01, 8'h01, 8'h11, 8'h12, 8'h00};
    logic s_tab [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic f_tab [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [7:0] exp_c;

    zcd_front_model u_front (.sink_cmd(sink_cmd), .sink_active(sink_active));
    zcd_ctrl u_dut (.clk(clk), .rst_n(rst_n), .sink_active(sink_active), .poweron_disable_fuse(fuse),
        .detector_enable(det_en), .zero_cross_irq_flag(flag), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // verdict and end of run
    task close_out;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // handshakes are judged at the negedge, which holds the values the next rising edge samples
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ta, tw, done;
        n = 0;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done)
        begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid && bready;
            if (done)
                `CHK(bresp, er)
            @(posedge clk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            if (done)
                bready <= 1'b0;
            n++;
            if (n > 40)
            begin
                n_errors++;
                close_out();
            end
        end
        // one idle edge so a following call never reassigns bready in this time step
        @(posedge clk);
    endtask

    // one read, compared against the expected word and response
    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic ta, done;
        n = 0;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done)
        begin
            @(negedge clk);
            ta = arvalid && arready;
            done = rvalid && rready;
            if (done)
            begin
                `CHK(rdata, ed)
                `CHK(rresp, er)
            end
            @(posedge clk);
            if (ta)
                arvalid <= 1'b0;
            if (done)
                rready <= 1'b0;
            n++;
            if (n > 40)
            begin
                n_errors++;
                close_out();
            end
        end
        // one idle edge so a following call never reassigns rready in this time step
        @(posedge clk);
    endtask

    // main sequence
    initial
    begin
        {rst_n, sink_cmd, fuse, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
        {awaddr, araddr, wdata} = 40'h00_0000_0000;
        wstrb = 4'hf;
        n_errors = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(det_en, 1'b1)
        rd(zcd_pkg::ZCD_CTRL_ADDR, 32'h0000_0080, zcd_pkg::ZCD_RESP_OKAY);
        // all low bits written with the enable off: the polarity change alone must raise the flag
        wr(zcd_pkg::ZCD_CTRL_ADDR, 32'h0000_007f, zcd_pkg::ZCD_RESP_OKAY);
        repeat (4) @(posedge clk);
        rd(zcd_pkg::ZCD_CTRL_ADDR, 32'h0000_0033, zcd_pkg::ZCD_RESP_OKAY);
        `CHK(flag, 1'b1)
        `CHK(det_en, 1'b0)
        rd(zcd_pkg::ZCD_FLAG_ADDR, 32'h0000_0001, zcd_pkg::ZCD_RESP_OKAY);
        // edge table: each step clears the flag, then moves the front end
        for (int i = 0; i < 7; i++)
        begin
            wr(zcd_pkg::ZCD_CTRL_ADDR, {24'h00_0000, c_tab[i]}, zcd_pkg::ZCD_RESP_OKAY);
            repeat (4) @(posedge clk);
            wr(zcd_pkg::ZCD_FLAG_ADDR, 32'h0000_0001, zcd_pkg::ZCD_RESP_OKAY);
            sink_cmd <= s_tab[i];
            repeat (6) @(posedge clk);
            `CHK(flag, f_tab[i])
            exp_c = c_tab[i];
            exp_c[5] = s_tab[i] ^ c_tab[i][4];
            rd(zcd_pkg::ZCD_CTRL_ADDR, {24'h00_0000, exp_c}, zcd_pkg::ZCD_RESP_OKAY);
        end
        rd(4'h8, 32'h0000_0000, zcd_pkg::ZCD_RESP_SLVERR);
        wr(4'h8, 32'h0000_00ff, zcd_pkg::ZCD_RESP_SLVERR);
        // second reset with the disable fuse set: software must turn the detector on
        fuse <= 1'b1;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // the synchroniser needs three edges before the status bit shows the front end again
        repeat (4) @(posedge clk);
        `CHK(det_en, 1'b0)
        rd(zcd_pkg::ZCD_CTRL_ADDR, 32'h0000_0020, zcd_pkg::ZCD_RESP_OKAY);
        wr(zcd_pkg::ZCD_CTRL_ADDR, 32'h0000_0080, zcd_pkg::ZCD_RESP_OKAY);
        rd(zcd_pkg::ZCD_CTRL_ADDR, 32'h0000_00a0, zcd_pkg::ZCD_RESP_OKAY);
        // a write that leaves byte 0 unstrobed must not touch the register
        wstrb <= 4'he;
        wr(zcd_pkg::ZCD_CTRL_ADDR, 32'h0000_0000, zcd_pkg::ZCD_RESP_OKAY);
        wstrb <= 4'hf;
        rd(zcd_pkg::ZCD_CTRL_ADDR, 32'h0000_00a0, zcd_pkg::ZCD_RESP_OKAY);
        close_out();
    end
endmodule
